// file: shared/acs_pkg.sv
`default_nettype none
package acs_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] SETUP_OFS  = 8'h00;
  localparam logic [7:0] TIMING_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS   = 8'h0C;
  localparam logic [7:0] ACCUM_OFS  = 8'h10;

  // ---------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ALU_NONE, ALU_AVG, ALU_MAX, ALU_MIN
  } acs_alu_t;

  typedef enum logic [1:0] {
    RSEL_AVG, RSEL_MIN, RSEL_MAX, RSEL_LAST
  } acs_rsel_t;

  // Setup register, bits [11:0]
  typedef struct packed {
    acs_alu_t   aluMode;
    logic       edgeRise;
    logic       external_trigger_select;
    logic [2:0] readMode;
    logic       refExternal;
    logic [2:0] channel_select_field;
    logic       enable;
  } acs_setup_t;

  // Timing register, bits [8:0]
  typedef struct packed {
    logic [1:0] auxBiasLevel;
    logic [2:0] waitCode;
    logic [3:0] delayCode;
  } acs_timing_t;

  // Latched cycle results
  typedef struct packed {
    logic [10:0] avg;
    logic [10:0] min;
    logic [10:0] max;
    logic [10:0] last;
  } acs_res_t;

  localparam int unsigned SETUP_W        = 12;
  localparam int unsigned TIMING_W       = 9;
  localparam int unsigned RES_SEL_LSB    = 12;
  localparam int unsigned RES_STATUS_BIT = 15;
  localparam int unsigned MASK_DONE_BIT  = 0;

  localparam logic [11:0] SETUP_RST  = 12'h000;
  localparam logic [8:0]  TIMING_RST = 9'h000;
  localparam logic        MASK_RST   = 1'b1;
  localparam logic [9:0]  SAR_MSB    = 10'h200;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned DELAY_STEP_NS = 50000;
  localparam int unsigned WAIT_STEP_NS  = 20000;
  localparam int unsigned SAR_SETTLE_NS = 200;
  localparam int unsigned DELAY_STEP_CYC = DELAY_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned WAIT_STEP_CYC  = WAIT_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned SAR_SETTLE_CYC =
    (SAR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : acs_pkg
`default_nettype wire

// file: rtl/acs_adc_cycle_sequencer.sv
// What this block does
// - Route one of eight inputs to the converter by channel select.
// - Convert each sample to a 10-bit successive-approximation code.
// - Keep the ALU result in an 11-bit accumulator with carry bit.
// - Samples per cycle follow the sample-count field, 1 to 256.
// - ALU mode: average, maximum, minimum or plain last sample.
// - Always compute minimum, maximum and average every cycle.
// - Hand each sample to the ALU; at cycle end move results, status.
// - Cycle ends: final ALU step, result transfer, then status low.
// - Internal trigger restarts conversion after wait timing.
// - External trigger mode waits for a pin edge, then timing.
// - A cycle starts on the enable bit rising.
// - Configuration holds until the cycle ends, even if enable drops.
// - Done clears status and, if unmasked, pulls interrupt low.
// - Result select picks average, min, max or last for reading.
// - One-sample cycles give equal min, max, average and last.
// - Result select cannot change while a cycle runs.
// - Reference select; external reference turns internal regulator off.
// - Thermistor and first aux bias on whenever input power present.
// - Aux bias level from timing register; thermistor bias fixed.
// - Channel comes from the host-written channel select field.
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module acs_adc_cycle_sequencer #(
  parameter int unsigned DELAY_STEP_CYC = acs_pkg::DELAY_STEP_CYC,
  parameter int unsigned WAIT_STEP_CYC  = acs_pkg::WAIT_STEP_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        trigger_input_pin,
  input  wire logic        compHigh,
  input  wire logic        powerDetected,
  output logic [2:0]       muxSel,
  output logic [9:0]       sarCode,
  output logic             intRegEnable,
  output logic             biasEnThermistor,
  output logic             biasEnAuxOne,
  output logic [1:0]       auxBiasLevel,
  output logic             irq_n
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ARM, ST_DELAY, ST_CONV, ST_ALU, ST_WAIT, ST_XFER, ST_DONE
  } acs_state_t;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic trigS1, trigS2, trigS3;
  logic compS1, compS2;
  logic pwrS1,  pwrS2;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {trigS1, trigS2, trigS3} <= 3'h0;
      {compS1, compS2}         <= 2'h0;
      {pwrS1, pwrS2}           <= 2'h0;
    end else begin
      trigS1 <= trigger_input_pin;
      trigS2 <= trigS1;
      trigS3 <= trigS2;
      compS1 <= compHigh;
      compS2 <= compS1;
      pwrS1  <= powerDetected;
      pwrS2  <= pwrS1;
    end
  end

  // ---------------------------------------------------------------
  // Registers and bus slave
  // ---------------------------------------------------------------
  acs_pkg::acs_setup_t  setup_r;
  acs_pkg::acs_timing_t timing_r;
  acs_pkg::acs_setup_t  cfg_r;
  acs_pkg::acs_rsel_t   resSel_r;
  acs_pkg::acs_res_t    res_r;
  acs_state_t           state_r;
  logic        maskDone_r;
  logic        busy_r;
  logic        startPulse_r;
  logic        wrPend_r;
  logic        rdPend_r;
  logic [7:0]  addrQ_r;
  logic [10:0] acc_r;
  logic [31:0] rdMux;
  logic        doneEvt;

  assign doneEvt = (state_r == ST_DONE);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_r  <= 1'b0;
      rdPend_r  <= 1'b0;
      addrQ_r   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      if (rdPend_r) begin
        // One wait state lets a read see a write made just before it
        hrdata    <= rdMux;
        hreadyout <= 1'b1;
      end else if (hsel && htrans[1] && hready) begin
        addrQ_r   <= haddr[7:0];
        wrPend_r  <= hwrite;
        rdPend_r  <= !hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    if (addrQ_r == acs_pkg::SETUP_OFS) begin
      rdMux[acs_pkg::SETUP_W-1:0] = setup_r;
    end else if (addrQ_r == acs_pkg::TIMING_OFS) begin
      rdMux[acs_pkg::TIMING_W-1:0] = timing_r;
    end else if (addrQ_r == acs_pkg::RESULT_OFS) begin
      case (resSel_r)
        acs_pkg::RSEL_AVG: rdMux[10:0] = res_r.avg;
        acs_pkg::RSEL_MIN: rdMux[10:0] = res_r.min;
        acs_pkg::RSEL_MAX: rdMux[10:0] = res_r.max;
        default:           rdMux[10:0] = res_r.last;
      endcase
      rdMux[acs_pkg::RES_SEL_LSB+:2]   = resSel_r;
      rdMux[acs_pkg::RES_STATUS_BIT]   = busy_r;
    end else if (addrQ_r == acs_pkg::MASK_OFS) begin
      rdMux[acs_pkg::MASK_DONE_BIT] = maskDone_r;
    end else if (addrQ_r == acs_pkg::ACCUM_OFS) begin
      rdMux[10:0] = acc_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      setup_r      <= acs_pkg::SETUP_RST;
      timing_r     <= acs_pkg::TIMING_RST;
      maskDone_r   <= acs_pkg::MASK_RST;
      resSel_r     <= acs_pkg::RSEL_AVG;
      startPulse_r <= 1'b0;
    end else begin
      startPulse_r <= 1'b0;
      if (wrPend_r) begin
        if (addrQ_r == acs_pkg::SETUP_OFS) begin
          setup_r <= hwdata[acs_pkg::SETUP_W-1:0];
          if (hwdata[0] && !setup_r.enable) begin
            startPulse_r <= 1'b1;
          end
        end else if (addrQ_r == acs_pkg::TIMING_OFS) begin
          timing_r <= hwdata[acs_pkg::TIMING_W-1:0];
        end else if (addrQ_r == acs_pkg::RESULT_OFS) begin
          if (!busy_r) begin
            resSel_r <= acs_pkg::acs_rsel_t'(hwdata[acs_pkg::RES_SEL_LSB+:2]);
          end
        end else if (addrQ_r == acs_pkg::MASK_OFS) begin
          maskDone_r <= hwdata[acs_pkg::MASK_DONE_BIT];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic [15:0] timer_r;
  logic [3:0]  bitIdx_r;
  logic [3:0]  settle_r;
  logic [8:0]  count_r;
  logic [9:0]  sample_r;
  logic [17:0] sum_r;
  logic [9:0]  min_r, max_r;
  logic        firstDone_r;
  logic [8:0]  lastIdx;
  logic [3:0]  avgShift;
  logic [17:0] avgWide;
  logic [15:0] delayCnt;
  logic [15:0] waitCnt;
  logic        trigActive;
  logic        trigEdge;
  logic [9:0]  sarDecided;
  logic [9:0]  nextMin, nextMax;

  // sample count: 1, 4, 8 ... 256
  assign lastIdx  = (cfg_r.readMode == 3'h0) ? 9'h000 :
                    9'((10'h001 << (4'(cfg_r.readMode) + 4'h1)) - 10'h001);
  assign avgShift = (cfg_r.readMode == 3'h0) ? 4'h0 :
                    4'(cfg_r.readMode) + 4'h1;
  assign avgWide  = sum_r >> avgShift;
  assign delayCnt = 16'(timing_r.delayCode * DELAY_STEP_CYC);
  assign waitCnt  = 16'((timing_r.waitCode + 3'h1) * WAIT_STEP_CYC);
  assign trigActive = cfg_r.edgeRise ? trigS2 : !trigS2;
  assign trigEdge   = cfg_r.edgeRise ? (trigS2 && !trigS3)
                                     : (!trigS2 && trigS3);
  assign sarDecided = compS2 ? sarCode : (sarCode & ~(10'h001 << bitIdx_r));
  // first sample seeds min and max
  assign nextMin = (!firstDone_r || sarDecided < min_r) ? sarDecided : min_r;
  assign nextMax = (!firstDone_r || sarDecided > max_r) ? sarDecided : max_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      cfg_r    <= acs_pkg::SETUP_RST;
      busy_r   <= 1'b0;
      timer_r  <= 16'h0000;
      bitIdx_r <= 4'h0;
      settle_r <= 4'h0;
      count_r  <= 9'h000;
      sarCode  <= 10'h000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (startPulse_r) begin
            // configuration held for the whole cycle
            cfg_r   <= setup_r;
            busy_r  <= 1'b1;
            count_r <= 9'h000;
            timer_r <= delayCnt;
            state_r <= setup_r.external_trigger_select ? ST_ARM : ST_DELAY;
          end
        end
        ST_ARM: begin
          // wait for the programmed pin edge
          if (trigEdge) begin
            timer_r <= delayCnt;
            state_r <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (timer_r != 16'h0000) begin
            timer_r <= timer_r - 16'h0001;
          end else if (cfg_r.external_trigger_select && !trigActive) begin
            // Trigger level not active when the delay ends: re-arm
            state_r <= ST_ARM;
          end else begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (bitIdx_r == 4'h9 && settle_r == 4'h0 && sarCode == 10'h000) begin
            sarCode  <= acs_pkg::SAR_MSB;
            settle_r <= 4'(acs_pkg::SAR_SETTLE_CYC);
          end else if (settle_r != 4'h0) begin
            settle_r <= settle_r - 4'h1;
          end else if (bitIdx_r == 4'h0) begin
            sarCode  <= sarDecided;
            state_r  <= ST_ALU;
          end else begin
            sarCode  <= sarDecided | (10'h001 << (bitIdx_r - 4'h1));
            bitIdx_r <= bitIdx_r - 4'h1;
            settle_r <= 4'(acs_pkg::SAR_SETTLE_CYC);
          end
        end
        ST_ALU: begin
          bitIdx_r <= 4'h9;
          sarCode  <= 10'h000;
          count_r  <= count_r + 9'h001;
          if (count_r == lastIdx) begin
            state_r <= ST_XFER;
          end else begin
            timer_r <= waitCnt;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // next conversion after the wait time
          if (timer_r != 16'h0000) begin
            timer_r <= timer_r - 16'h0001;
          end else begin
            state_r <= ST_CONV;
          end
        end
        ST_XFER: begin
          state_r <= ST_DONE;
        end
        default: begin
          busy_r  <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
      if (state_r == ST_IDLE && !startPulse_r) begin
        bitIdx_r <= 4'h9;
        settle_r <= 4'h0;
        sarCode  <= 10'h000;
      end
    end
  end

  // ---------------------------------------------------------------
  // ALU and result transfer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sum_r       <= 18'h00000;
      min_r       <= 10'h000;
      max_r       <= 10'h000;
      sample_r    <= 10'h000;
      firstDone_r <= 1'b0;
      acc_r       <= 11'h000;
      res_r       <= '0;
    end else if (state_r == ST_IDLE && startPulse_r) begin
      sum_r       <= 18'h00000;
      firstDone_r <= 1'b0;
    end else if (state_r == ST_CONV && settle_r == 4'h0 &&
                 bitIdx_r == 4'h0) begin
      // engine output handed to the ALU; all stats kept
      sample_r    <= sarDecided;
      sum_r       <= sum_r + 18'(sarDecided);
      min_r       <= nextMin;
      max_r       <= nextMax;
      firstDone_r <= 1'b1;
    end else if (state_r == ST_ALU) begin
      case (cfg_r.aluMode)
        acs_pkg::ALU_MAX: acc_r <= {1'b0, max_r};
        acs_pkg::ALU_MIN: acc_r <= {1'b0, min_r};
        acs_pkg::ALU_AVG: acc_r <= avgWide[10:0];
        default:          acc_r <= {1'b0, sample_r};
      endcase
    end else if (state_r == ST_XFER) begin
      // results move to the readable set
      res_r.avg  <= avgWide[10:0];
      res_r.min  <= {1'b0, min_r};
      res_r.max  <= {1'b0, max_r};
      res_r.last <= {1'b0, sample_r};
    end
  end

  // ---------------------------------------------------------------
  // Analog controls and interrupt
  // ---------------------------------------------------------------
  logic irqPend_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqPend_r <= 1'b0;
      irq_n     <= 1'b1;
    end else begin
      // Set wins over the clear of a new start
      if (doneEvt) begin
        irqPend_r <= 1'b1;
      end else if (startPulse_r) begin
        irqPend_r <= 1'b0;
      end
      // unmasked done pulls the line low
      irq_n <= !((irqPend_r || doneEvt) && !maskDone_r);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      muxSel           <= 3'h0;
      intRegEnable     <= 1'b1;
      biasEnThermistor <= 1'b0;
      biasEnAuxOne     <= 1'b0;
      auxBiasLevel     <= 2'h0;
    end else begin
      muxSel           <= busy_r ? cfg_r.channel_select_field
                                 : setup_r.channel_select_field;
      intRegEnable     <= !(busy_r ? cfg_r.refExternal
                                   : setup_r.refExternal);
      biasEnThermistor <= pwrS2;
      biasEnAuxOne     <= pwrS2;
      auxBiasLevel     <= timing_r.auxBiasLevel;
    end
  end

endmodule : acs_adc_cycle_sequencer
`default_nettype wire

// file: tb/acs_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module acs_analog_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [2:0] muxSel,
  input  wire logic [9:0] sarCode,
  output logic            compHigh
);
  logic [7:0] loads_r;
  logic       wasLoad_r;
  logic [9:0] level;
  // Odd and even samples differ by 8 so min, max and mean part ways
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loads_r   <= 8'h00;
      wasLoad_r <= 1'h0;
    end else begin
      wasLoad_r <= sarCode == acs_pkg::SAR_MSB;
      if (sarCode == acs_pkg::SAR_MSB && !wasLoad_r) begin
        loads_r <= loads_r + 8'h01;
      end
    end
  end
  assign level = {muxSel, 7'h15} + (loads_r[0] ? 10'h000 : 10'h008);
  assign compHigh = level >= sarCode;
endmodule : acs_analog_model
`default_nettype wire

// file: tb/acs_adc_cycle_sequencer_checker.sv
`timescale 1ns/1ns
`default_nettype none
module acs_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        trigger_input_pin,
  input wire logic        compHigh,
  input wire logic        powerDetected,
  input wire logic [2:0]  muxSel,
  input wire logic [9:0]  sarCode,
  input wire logic        intRegEnable,
  input wire logic        biasEnThermistor,
  input wire logic        biasEnAuxOne,
  input wire logic [1:0]  auxBiasLevel,
  input wire logic        irq_n
);
  // ---------------------------------------------------------------
  // Shadow of host writes
  // ---------------------------------------------------------------
  logic       apWr_r, refShadow_r, enShadow_r, maskShadow_r;
  logic [7:0] apAddr_r;
  logic [1:0] auxShadow_r;
  logic       taken, wrDone, wrSetup, wrTiming;
  assign taken    = hsel && htrans[1] && hready;
  assign wrDone   = apWr_r && hready;
  assign wrSetup  = wrDone && apAddr_r == acs_pkg::SETUP_OFS;
  assign wrTiming = wrDone && apAddr_r == acs_pkg::TIMING_OFS;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      apWr_r   <= 1'h0;
      apAddr_r <= 8'h00;
    end else if (hready) begin
      apWr_r   <= taken && hwrite;
      apAddr_r <= haddr[7:0];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      refShadow_r  <= 1'h0;
      enShadow_r   <= 1'h0;
      maskShadow_r <= 1'h1;
      auxShadow_r  <= 2'h0;
    end else if (wrDone) begin
      if (apAddr_r == acs_pkg::SETUP_OFS) begin
        refShadow_r <= hwdata[4];
        enShadow_r  <= hwdata[0];
      end
      if (apAddr_r == acs_pkg::TIMING_OFS) begin
        auxShadow_r <= hwdata[8:7];
      end
      if (apAddr_r == acs_pkg::MASK_OFS) begin
        maskShadow_r <= hwdata[0];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_write_ready: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_read_wait: assert property
    (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_resp_okay: assert property (!hresp)
    else $error("response not okay");
  chk_bias_high: assert property (powerDetected [*4] |-> biasEnThermistor)
    else $error("bias off with power present");
  chk_bias_low: assert property (!powerDetected [*4] |-> !biasEnThermistor)
    else $error("bias on without power");
  chk_bias_pair: assert property (biasEnThermistor == biasEnAuxOne)
    else $error("bias sources disagree");
  chk_aux_level: assert property (wrTiming |-> ##2 auxBiasLevel == auxShadow_r)
    else $error("aux bias level not written");
  chk_ref_select: assert property (wrSetup |-> ##2 intRegEnable == !refShadow_r)
    else $error("regulator enable wrong");
  chk_irq_masked: assert property (maskShadow_r [*3] |-> irq_n)
    else $error("interrupt while masked");
  chk_irq_release: assert property
    (wrSetup && hwdata[0] && !enShadow_r |-> ##[1:3] irq_n)
    else $error("interrupt held over new start");
  chk_sar_settle: assert property
    ($changed(sarCode) && sarCode != 10'h000 && !$past(sarCode[0])
     |=> $stable(sarCode) [*4])
    else $error("trial code changed too soon");
  cover property (taken && !hwrite);
  cover property ($fell(irq_n));
  cover property ($rose(biasEnThermistor));
  cover property ($fell(intRegEnable));
endmodule : acs_checker
bind acs_adc_cycle_sequencer acs_checker u_chk (
  .clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .hreadyout, .hrdata, .hresp, .trigger_input_pin, .compHigh,
  .powerDetected, .muxSel, .sarCode, .intRegEnable, .biasEnThermistor,
  .biasEnAuxOne, .auxBiasLevel, .irq_n);
`default_nettype wire

// file: tb/test_adc_cycle_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module test_adc_cycle_sequencer;
  logic        clk_sys, rst_n, hsel, hwrite, hreadyout, hresp, irq_n;
  logic        trigger_input_pin, powerDetected, compHigh, intRegEnable;
  logic        biasEnThermistor, biasEnAuxOne;
  logic [1:0]  htrans, auxBiasLevel;
  logic [2:0]  hsize, muxSel;
  logic [9:0]  sarCode;
  logic [31:0] haddr, hwdata, hrdata, rdq;
  int          err_total, check_count, cyc;

  always #20 clk_sys = ~clk_sys;

  acs_adc_cycle_sequencer #(.DELAY_STEP_CYC(4), .WAIT_STEP_CYC(3)) DUT (
    .clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .trigger_input_pin,
    .compHigh, .powerDetected, .muxSel, .sarCode, .intRegEnable,
    .biasEnThermistor, .biasEnAuxOne, .auxBiasLevel, .irq_n);
  acs_analog_model u_model (.clk_sys, .rst_n, .muxSel, .sarCode, .compHigh);

  // ---------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'h1);
    rdq = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
  endtask : rd

  function automatic logic [11:0] mk(input logic [1:0] alu,
    input logic ext, input logic [2:0] rm, input logic [2:0] ch);
    return {alu, 1'h1, ext, rm, 1'h0, ch, 1'h1};
  endfunction : mk

  task automatic start(input logic [11:0] s);
    wr(acs_pkg::SETUP_OFS, {20'h0, s[11:1], 1'h0});
    wr(acs_pkg::SETUP_OFS, {20'h0, s});
  endtask : start

  task automatic wait_done();
    int n;
    n = 0;
    repeat (3) @(posedge clk_sys);
    do begin
      rd(acs_pkg::RESULT_OFS);
      n++;
    end while (rdq[15] !== 1'h0 && n < 500);
    chk(rdq[15], 32'h0);
  endtask : wait_done

  task automatic chk_sel(input logic [10:0] b, input logic one);
    logic [10:0] e;
    for (int s = 0; s < 4; s++) begin
      e = one ? b : (s == 0) ? b + 11'h004 : (s == 1) ? b : b + 11'h008;
      wr(acs_pkg::RESULT_OFS, 32'(s) << 12);
      rd(acs_pkg::RESULT_OFS);
      chk({rdq[15], rdq[13:12], rdq[10:0]}, {1'h0, 2'(s), e});
    end
  endtask : chk_sel

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(acs_pkg::SETUP_OFS);
    chk(rdq, 32'h0);
    rd(acs_pkg::TIMING_OFS);
    chk(rdq, 32'h0);
    rd(acs_pkg::MASK_OFS);
    chk(rdq, 32'h1);
    rd(8'h14);
    chk(rdq, 32'h0);
    chk(irq_n, 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_static();
    wr(acs_pkg::TIMING_OFS, 32'h110);
    repeat (3) @(negedge clk_sys);
    chk(auxBiasLevel, 32'h2);
    wr(acs_pkg::SETUP_OFS, 32'h10);
    repeat (3) @(negedge clk_sys);
    chk(intRegEnable, 32'h0);
    wr(acs_pkg::SETUP_OFS, 32'h0);
    repeat (3) @(negedge clk_sys);
    chk(intRegEnable, 32'h1);
    @(posedge clk_sys);
    powerDetected <= 1'h1;
    repeat (5) @(negedge clk_sys);
    chk({biasEnThermistor, biasEnAuxOne}, 32'h3);
    $display("test static done");
  endtask : t_static

  task automatic t_alu();
    for (int m = 0; m < 4; m++) begin
      start(mk(2'(m), 1'h0, 3'h1, 3'h5));
      repeat (10) @(negedge clk_sys);
      chk(muxSel, 32'h5);
      wait_done();
      rd(acs_pkg::ACCUM_OFS);
      chk(rdq[10:0], m == 3 ? 32'h295 : m == 1 ? 32'h299 : 32'h29D);
      chk_sel(11'h295, 1'h0);
    end
    $display("test alu done");
  endtask : t_alu

  task automatic t_busy();
    wr(acs_pkg::RESULT_OFS, 32'h0);
    start(mk(2'h1, 1'h0, 3'h1, 3'h3));
    repeat (20) @(posedge clk_sys);
    wr(acs_pkg::RESULT_OFS, 32'h3000);
    rd(acs_pkg::RESULT_OFS);
    chk({rdq[15], rdq[13:12]}, 32'h4);
    // Enable dropped mid-cycle with another channel on purpose
    wr(acs_pkg::SETUP_OFS, {20'h0, mk(2'h1, 1'h0, 3'h1, 3'h6) & 12'hFFE});
    wait_done();
    rd(acs_pkg::RESULT_OFS);
    chk(rdq[10:0], 32'h199);
    $display("test busy done");
  endtask : t_busy

  task automatic t_ext();
    start(mk(2'h1, 1'h1, 3'h1, 3'h2));
    repeat (300) @(posedge clk_sys);
    rd(acs_pkg::RESULT_OFS);
    chk(rdq[15], 32'h1);
    trigger_input_pin <= 1'h1;
    wait_done();
    rd(acs_pkg::RESULT_OFS);
    chk(rdq[10:0], 32'h119);
    trigger_input_pin <= 1'h0;
    $display("test ext done");
  endtask : t_ext

  task automatic t_irq();
    wr(acs_pkg::MASK_OFS, 32'h0);
    repeat (3) @(negedge clk_sys);
    chk(irq_n, 32'h0);
    start(mk(2'h0, 1'h0, 3'h1, 3'h4));
    repeat (3) @(negedge clk_sys);
    chk(irq_n, 32'h1);
    wait_done();
    @(negedge clk_sys);
    chk(irq_n, 32'h0);
    wr(acs_pkg::MASK_OFS, 32'h1);
    $display("test irq done");
  endtask : t_irq

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    clk_sys = 1'h0;
    rst_n = 1'h0;
    hsel = 1'h1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    trigger_input_pin = 1'h0;
    powerDetected = 1'h0;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_reset();
    t_static();
    t_alu();
    t_busy();
    t_ext();
    t_irq();
    start(mk(2'h3, 1'h0, 3'h0, 3'h7));
    wait_done();
    chk_sel(11'h395, 1'h1);
    $display("test one sample done");
    report_and_stop();
  end
endmodule : test_adc_cycle_sequencer
`default_nettype wire
